// ---- design/erp_pkg.sv ----
// Constants, carrier types and rule notes for the event readout port
// Functional notes
// - Block new events once FIFO is half full
// - Header plus at most 512 data words
// - Buffer holds eight full single-word events
// - Buffer depth covers four double-word events too
// - Bus read answers Q=1, then Q=0 after event
// - After Q=0, next read starts next event
// - Busy also readable through bus status
// - Buffered busy: end of acquisition until stored
// - Unbuffered busy: delayed, held until FIFO empty
// - Request delay 2 to 30 us, 2 us steps; code takes 0 to 30 us, setting 0 gives no delay
// - Multi-event port: one event per token arrival
// - Early token waits until an event is ready
// - After event, raise pass until token falls
// - Single-buffer: token low pauses word transfer; with fast port the code pauses on acknowledge only, not on token
// - Single-buffer: after readout, copy token to pass
// - Normal port: strobe waits for acknowledge
// - Fast port: ignore handshake, 10 Mwords/s
// - Fast port: acknowledge high pauses after word
// - Suppressed empty event emits nothing, still counted
// - Header: id, resolution, edge, serial, 0, 1
// - Data word: time, channel, bit 15 clear
// - Same word formats for bus and port
// - Fast port select is control 1 bit 12
// - Header suppress is control 0 bit 13
// - Serial number increments per event, read/write
// - Module id from control 0 bits 0-7
package erp_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL0  = 6'h00;
  localparam logic [5:0] IDX_CTRL1  = 6'h01;
  localparam logic [5:0] IDX_CTRL3  = 6'h03;
  localparam logic [5:0] IDX_DATA   = 6'h08;
  localparam logic [5:0] IDX_STATUS = 6'h09;

  // Control 0 fields
  localparam int C0_ID_LSB    = 0;
  localparam int C0_RES_LSB   = 8;
  localparam int C0_EDGE      = 10;
  localparam int C0_PORT_MODE = 11;
  localparam int C0_MULTI_BUF = 12;
  localparam int C0_HDR_SUPP  = 13;
  // Control 1 fields
  localparam int C1_FAST      = 12;
  localparam int C1_SERIAL    = 13;
  // Status fields, then the Q bit of data reads
  localparam int ST_BUSY      = 0;
  localparam int ST_BLOCK     = 1;
  localparam int ST_WRITING   = 2;
  localparam int ST_EVT_LSB   = 4;
  localparam int ST_OCC_LSB   = 16;
  localparam int DATA_Q       = 16;

  localparam logic [15:0] CTRL0_RST = 16'h0000;
  localparam logic [15:0] CTRL1_RST = 16'h0000;
  localparam logic [3:0]  CTRL3_RST = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Event buffer
  localparam int          FIFO_DEPTH  = 8192;
  localparam int          FIFO_AW     = 13;
  localparam logic [12:0] FIFO_LIMIT  = 13'hFFF;
  localparam logic [9:0]  MAX_DATA    = 10'h200;

  // Timing at 40 MHz
  localparam int          CLK_HZ         = 40000000;
  localparam int          REQ_STEP_US    = 2;
  localparam logic [10:0] REQ_STEP_CYC   = 11'(REQ_STEP_US * (CLK_HZ / 1000000));
  localparam int          FAST_WORDS_PS  = 10000000;
  localparam int          FAST_WORD_CYC  = CLK_HZ / FAST_WORDS_PS;
  localparam logic [1:0]  FAST_HIGH_CYC  = 2'(FAST_WORD_CYC / 2);
  localparam logic [1:0]  FAST_GAP_CYC   = 2'(FAST_WORD_CYC - FAST_WORD_CYC / 2 - 1);

  typedef struct packed {
    logic [4:0] channel;
    logic [9:0] timeValue;
  } erp_hit_t;

  typedef struct packed {
    logic        tag;
    logic [15:0] data;
  } erp_fifo_word_t;

endpackage

// ---- design/erp_event_readout_port.sv ----
// Event buffer with crate-bus and ECL port readout
`timescale 1ns/1ps
module erp_event_readout_port
  import erp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        acqEnd,
  input  wire logic        hitValid,
  output logic             hitReady,
  input  wire erp_hit_t    hitData,
  input  wire logic        convDone,
  input  wire logic        readoutToken,
  input  wire logic        wordAcknowledge,
  output logic [15:0]      eclDataPort,
  output logic             wordStrobe,
  output logic             passToken,
  output logic             busy
);

  typedef enum logic [2:0] {
    PS_IDLE, PS_STROBE, PS_ACKWAIT, PS_GAP, PS_NEXT, PS_PASS
  } erp_port_state_t;

  function automatic logic [15:0] mergeLanes(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    mergeLanes = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  erp_fifo_word_t  mem [FIFO_DEPTH];
  logic [15:0]     ctrl0;
  logic [15:0]     ctrl1;
  logic [3:0]      ctrl3;
  logic [FIFO_AW-1:0] wrPtr, rdPtr, commitPtr, occupancy;
  logic [11:0]     eventsHeld;
  logic            inEvent, writing, hdrDone, hdrSuppLatched;
  logic [9:0]      dataCount;
  logic            tokSync1, tokSync, ackSync1, ackSync;
  logic [7:0]      awAddr;
  logic [31:0]     wData;
  logic [3:0]      wStrb;
  logic            awHeld, wHeld;
  logic [10:0]     delayCnt;
  logic            delayRun, unbufBusy, passCopy;
  logic [1:0]      paceCnt;
  erp_port_state_t portState;

  logic            portMode, multiBuf, hdrSupp, fastMode;
  logic [2:0]      serial;
  logic            blockNew, acqTake, hdrWrite, dataWrite, doneAccept, wordAvail;
  logic            busRead, busPop, busClose, portPop, portClose, portPause, doWrite;
  logic            fifoEmpty;
  erp_fifo_word_t  headWord, memWord;

  assign portMode  = ctrl0[C0_PORT_MODE];
  assign multiBuf  = ctrl0[C0_MULTI_BUF];
  assign hdrSupp   = ctrl0[C0_HDR_SUPP];
  assign fastMode  = ctrl1[C1_FAST];
  assign serial    = ctrl1[C1_SERIAL +: 3];
  assign occupancy = wrPtr - rdPtr;
  assign fifoEmpty = (wrPtr == rdPtr);
  assign blockNew  = (occupancy >= FIFO_LIMIT);
  assign acqTake   = acqEnd && !writing && !blockNew;
  assign headWord  = mem[rdPtr];

  // Tag marks each header, so readout sees where an event begins and ends
  assign hdrWrite   = writing && !hdrDone && (!hdrSuppLatched || hitValid);
  assign dataWrite  = writing && hdrDone && hitValid && hitReady
                      && (dataCount < MAX_DATA);
  assign doneAccept = writing && convDone && !hitValid
                      && (hdrDone || hdrSuppLatched);
  always_comb begin
    memWord = '0;
    if (hdrWrite) begin
      memWord.tag  = 1'b1;
      memWord.data = {1'b1, 1'b0, serial, ctrl0[C0_EDGE], ctrl0[C0_RES_LSB +: 2],
                      ctrl0[C0_ID_LSB +: 8]};
    end else begin
      memWord.data = {1'b0, hitData.channel, hitData.timeValue};
    end
  end

  // Only words of committed events are visible to either reader
  assign wordAvail = inEvent ? (rdPtr != commitPtr && !headWord.tag)
                             : (eventsHeld != 12'h000);
  assign busRead   = arvalid && arready && !portMode && araddr[7:2] == IDX_DATA;
  assign busPop    = busRead && wordAvail;
  assign busClose  = busRead && !wordAvail && inEvent;
  assign portPause = fastMode ? ackSync : (!multiBuf && !tokSync);
  assign portPop   = portMode && ((portState == PS_IDLE && tokSync && wordAvail && !inEvent)
                     || (portState == PS_NEXT && wordAvail && inEvent && !portPause));
  assign portClose = portMode && portState == PS_NEXT && inEvent && !wordAvail;
  assign doWrite   = awHeld && wHeld;

  // Depth fits eight 513-word or four 1025-word events under the limit
  always_ff @(posedge clk) begin
    if (hdrWrite || dataWrite) begin
      mem[wrPtr] <= memWord;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      writing        <= 1'b0;
      hdrDone        <= 1'b0;
      hdrSuppLatched <= 1'b0;
      hitReady       <= 1'b0;
      dataCount      <= '0;
      wrPtr          <= '0;
      commitPtr      <= '0;
    end else begin
      if (acqTake) begin
        writing        <= 1'b1;
        hdrSuppLatched <= hdrSupp;
        dataCount      <= '0;
      end
      if (hdrWrite || dataWrite) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (hdrWrite) begin
        hdrDone  <= 1'b1;
        hitReady <= 1'b1;
      end
      if (dataWrite) begin
        dataCount <= dataCount + 1'b1;
      end
      if (doneAccept) begin
        writing   <= 1'b0;
        hdrDone   <= 1'b0;
        hitReady  <= 1'b0;
        commitPtr <= wrPtr;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPtr      <= '0;
      inEvent    <= 1'b0;
      eventsHeld <= '0;
    end else begin
      if (busPop || portPop) begin
        rdPtr   <= rdPtr + 1'b1;
        inEvent <= 1'b1;
      end
      if (busClose || portClose) begin
        inEvent <= 1'b0;
      end
      eventsHeld <= eventsHeld + 12'(doneAccept && hdrDone)
                    - 12'(busClose || portClose);
    end
  end

  // Busy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      delayRun  <= 1'b0;
      delayCnt  <= '0;
      unbufBusy <= 1'b0;
      busy      <= 1'b0;
    end else begin
      if (acqTake && !multiBuf) begin
        delayRun <= 1'b1;
        delayCnt <= 11'(ctrl3 * REQ_STEP_CYC);
      end else if (delayRun) begin
        if (delayCnt == '0) begin
          delayRun  <= 1'b0;
          unbufBusy <= 1'b1;
        end else begin
          delayCnt <= delayCnt - 1'b1;
        end
      end else if (unbufBusy && fifoEmpty && !writing && !inEvent) begin
        unbufBusy <= 1'b0;
      end
      if (multiBuf) begin
        busy <= acqTake || (writing && !doneAccept) || blockNew;
      end else begin
        busy <= unbufBusy || blockNew;
      end
    end
  end

  // Port pins are asynchronous to clk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tokSync1 <= 1'b0;
      tokSync  <= 1'b0;
      ackSync1 <= 1'b0;
      ackSync  <= 1'b0;
    end else begin
      tokSync1 <= readoutToken;
      tokSync  <= tokSync1;
      ackSync1 <= wordAcknowledge;
      ackSync  <= ackSync1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portState   <= PS_IDLE;
      eclDataPort <= '0;
      wordStrobe  <= 1'b0;
      passToken   <= 1'b0;
      passCopy    <= 1'b0;
      paceCnt     <= '0;
    end else begin
      if (acqTake) begin
        passCopy <= 1'b0;
      end
      if (portPop) begin
        eclDataPort <= headWord.data;
        wordStrobe  <= 1'b1;
        paceCnt     <= '0;
      end
      case (portState)
        PS_IDLE: begin
          passToken <= passCopy && !acqTake && tokSync;
          if (portPop) begin
            portState <= PS_STROBE;
          end
        end
        PS_STROBE: begin
          if (fastMode) begin
            paceCnt <= paceCnt + 1'b1;
            if (paceCnt == FAST_HIGH_CYC - 2'h1) begin
              wordStrobe <= 1'b0;
              paceCnt    <= '0;
              portState  <= PS_GAP;
            end
          end else if (ackSync) begin
            wordStrobe <= 1'b0;
            portState  <= PS_ACKWAIT;
          end
        end
        PS_ACKWAIT: begin
          if (!ackSync) begin
            portState <= PS_NEXT;
          end
        end
        PS_GAP: begin
          paceCnt <= paceCnt + 1'b1;
          if (paceCnt >= FAST_GAP_CYC - 2'h1) begin
            portState <= PS_NEXT;
          end
        end
        PS_NEXT: begin
          if (portPop) begin
            portState <= PS_STROBE;
          end else if (portClose) begin
            if (multiBuf) begin
              passToken <= 1'b1;
              portState <= PS_PASS;
            end else begin
              passCopy  <= !acqTake;
              portState <= PS_IDLE;
            end
          end
        end
        PS_PASS: begin
          if (!tokSync) begin
            passToken <= 1'b0;
            portState <= PS_IDLE;
          end
        end
        default: portState <= PS_IDLE;
      endcase
    end
  end

  // Register slave; address and data may arrive in either order
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      awHeld  <= 1'b0;
      wHeld   <= 1'b0;
      awAddr  <= '0;
      wData   <= '0;
      wStrb   <= '0;
      ctrl0   <= CTRL0_RST;
      ctrl1   <= CTRL1_RST;
      ctrl3   <= CTRL3_RST;
    end else begin
      if (awvalid && awready) begin
        awAddr <= awaddr;
        awHeld <= 1'b1;
      end
      if (wvalid && wready) begin
        wData <= wdata;
        wStrb <= wstrb;
        wHeld <= 1'b1;
      end
      awready <= !(doWrite || bvalid || awHeld || (awvalid && awready));
      wready  <= !(doWrite || bvalid || wHeld || (wvalid && wready));
      if (doneAccept) begin
        ctrl1[C1_SERIAL +: 3] <= serial + 3'h1;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= RESP_OKAY;
        case (awAddr[7:2])
          IDX_CTRL0:  ctrl0 <= mergeLanes(ctrl0, wData, wStrb) & 16'h3FFF;
          IDX_CTRL1:  ctrl1 <= mergeLanes(ctrl1, wData, wStrb) & 16'hF000;
          IDX_CTRL3:  ctrl3 <= wStrb[0] ? wData[3:0] : ctrl3;
          IDX_DATA, IDX_STATUS: bresp <= RESP_OKAY;
          default:    bresp <= RESP_SLVERR;
        endcase
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= RESP_OKAY;
        rdata   <= '0;
        case (araddr[7:2])
          IDX_CTRL0:  rdata[15:0] <= ctrl0;
          IDX_CTRL1:  rdata[15:0] <= ctrl1;
          IDX_CTRL3:  rdata[3:0]  <= ctrl3;
          IDX_DATA:   rdata[16:0] <= busPop ? {1'b1, headWord.data} : 17'h00000;
          IDX_STATUS: begin
            rdata[ST_BUSY]              <= busy;
            rdata[ST_BLOCK]             <= blockNew;
            rdata[ST_WRITING]           <= writing;
            rdata[ST_EVT_LSB +: 12]     <= eventsHeld;
            rdata[ST_OCC_LSB +: FIFO_AW] <= occupancy;
          end
          default:    rresp <= RESP_SLVERR;
        endcase
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end else if (!rvalid) begin
        arready <= 1'b1;
      end
    end
  end

  property p_block_full;
    @(posedge clk) disable iff (!rst_n) acqEnd && !writing && blockNew |=> !writing;
  endproperty
  a_block_full: assert property (p_block_full) else $error("Event taken above limit");

  property p_cap_data;
    @(posedge clk) disable iff (!rst_n)
      doneAccept |-> 13'(wrPtr - commitPtr) <= 13'(MAX_DATA) + 13'h1;
  endproperty
  a_cap_data: assert property (p_cap_data) else $error("Too many data words");

  property p_q_zero;
    @(posedge clk) disable iff (!rst_n) busRead && !wordAvail |=> rvalid && rdata[DATA_Q] == 1'b0;
  endproperty
  a_q_zero: assert property (p_q_zero) else $error("Q not zero at event end");

  property p_buf_busy;
    @(posedge clk) disable iff (!rst_n) acqTake && multiBuf |=> busy;
  endproperty
  a_buf_busy: assert property (p_buf_busy) else $error("Busy missing at end of acquisition");

  property p_pass_hold;
    @(posedge clk) disable iff (!rst_n) portState == PS_PASS && tokSync |=> passToken;
  endproperty
  a_pass_hold: assert property (p_pass_hold) else $error("Pass dropped early");

  property p_pass_copy;
    @(posedge clk) disable iff (!rst_n)
      portState == PS_IDLE && passCopy && !acqTake |=> passToken == $past(tokSync);
  endproperty
  a_pass_copy: assert property (p_pass_copy) else $error("Pass not copying token");

  property p_fast_pace;
    @(posedge clk) disable iff (!rst_n)
      fastMode && $rose(wordStrobe) |-> wordStrobe ##1 wordStrobe ##1 !wordStrobe;
  endproperty
  a_fast_pace: assert property (p_fast_pace) else $error("Fast strobe width wrong");

  property p_header_fmt;
    @(posedge clk) disable iff (!rst_n) hdrWrite |-> memWord.data[15:14] == 2'b10 && memWord.tag;
  endproperty
  a_header_fmt: assert property (p_header_fmt) else $error("Bad header word");

  property p_serial_inc;
    @(posedge clk) disable iff (!rst_n)
      doneAccept && !doWrite |=> serial == 3'($past(serial) + 3'h1);
  endproperty
  a_serial_inc: assert property (p_serial_inc) else $error("Serial did not advance");

  c_bus_event: cover property (@(posedge clk) disable iff (!rst_n) busPop ##[1:20] busClose);
  c_port_pass: cover property (@(posedge clk) disable iff (!rst_n) portState == PS_PASS);
  c_suppress:  cover property (@(posedge clk) disable iff (!rst_n) doneAccept && !hdrDone);
  c_unbuf:     cover property (@(posedge clk) disable iff (!rst_n) $fell(unbufBusy));

endmodule // erp_event_readout_port

// ---- verification/erp_ctrl_model.sv ----
// Readout driver controller model: token grant, word acknowledge, word capture
`timescale 1ns/1ps
module erp_ctrl_model
  import erp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        grant,
  input  wire logic [1:0]  ackLag,
  input  wire logic        fastAck,
  input  wire logic        pauseReq,
  input  wire logic [15:0] eclDataPort,
  input  wire logic        wordStrobe,
  input  wire logic        passToken,
  output logic             readoutToken,
  output logic             wordAcknowledge
);
  logic [3:0]  ackPipe;
  logic        strobeLast;
  logic [15:0] got[$];

  // Token drops while pass stands, so one grant releases one event
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      readoutToken <= 1'b0;
    else
      readoutToken <= grant && !passToken;
  end

  // Lag tap gives a prompt or a slow acknowledge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ackPipe <= 4'h0;
    else
      ackPipe <= {ackPipe[2:0], wordStrobe};
  end
  // Fast port: acknowledge is a pause request, not an echo
  assign wordAcknowledge = fastAck ? pauseReq : ackPipe[ackLag];

  always @(posedge clk) begin
    strobeLast <= wordStrobe;
    if (wordStrobe && !strobeLast)
      got.push_back(eclDataPort);
  end
endmodule // erp_ctrl_model

// ---- verification/test_event_readout_port.sv ----
// Self-checking bench for the event readout port
`timescale 1ns/1ps
module test_event_readout_port;
  import erp_pkg::*;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        acqEnd, hitValid, convDone, grant, awready, wready, bvalid;
  logic        arready, rvalid, hitReady, readoutToken, wordAcknowledge;
  logic        wordStrobe, passToken, busy, fastAck, pauseReq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp, ackLag;
  logic [15:0] eclDataPort;
  erp_hit_t    hitData;
  int          mismatches, checked;
  localparam logic [7:0] A_C0 = {IDX_CTRL0, 2'b00};
  localparam logic [7:0] A_C1 = {IDX_CTRL1, 2'b00};
  localparam logic [7:0] A_C3 = {IDX_CTRL3, 2'b00};
  localparam logic [7:0] A_DAT = {IDX_DATA, 2'b00};
  localparam logic [7:0] A_ST = {IDX_STATUS, 2'b00};

  erp_event_readout_port DUT (.clk, .rst_n, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp, .acqEnd, .hitValid, .hitReady, .hitData, .convDone, .readoutToken,
    .wordAcknowledge, .eclDataPort, .wordStrobe, .passToken, .busy);
  erp_ctrl_model partner (.clk, .rst_n, .grant, .ackLag, .fastAck, .pauseReq, .eclDataPort, .wordStrobe,
    .passToken, .readoutToken, .wordAcknowledge);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic timeout;
    mismatches++;
    $display("[ERR] %0t wait ran out", $time);
    finish_test();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 100) timeout();
    rsp = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 100) timeout();
    rdv = rdata;
    rsp = rresp;
  endtask

  // Hits count up from the first value, so a boundary can be crossed
  task automatic startEvent(input int nHits, input logic [14:0] first);
    int i;
    int n;
    acqEnd <= 1'b1;
    @(posedge clk);
    acqEnd <= 1'b0;
    for (i = 0; i < nHits; i++) begin
      hitData <= erp_hit_t'(first + 15'(i));
      hitValid <= 1'b1;
      for (n = 0; n < 100; n++) begin
        @(posedge clk);
        if (hitReady) break;
      end
      if (n == 100) timeout();
    end
    hitValid <= 1'b0;
  endtask

  task automatic endEvent;
    @(posedge clk);
    convDone <= 1'b1;
    @(posedge clk);
    convDone <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic waitPass(input logic lvl);
    int n;
    for (n = 0; n < 300; n++) begin
      @(posedge clk);
      if (passToken === lvl) break;
    end
    if (n == 300) timeout();
  endtask

  function automatic logic [31:0] hdr(input logic [2:0] ser, input logic [2:0] resEdge);
    return {16'h0001, 2'b10, ser, resEdge, 8'hA5};
  endfunction

  task automatic regTest;
    rd(A_C0);
    check(rdv[15:0], 32'h0);
    rd(A_C1);
    check(rdv[15:0], 32'h0);
    rd(A_C3);
    check(rdv[3:0], 32'h0);
    wr(8'h40, 32'h1);
    check(rsp, RESP_SLVERR);
    rd(8'h40);
    check(rsp, RESP_SLVERR);
    wr(A_C0, 32'h16A5);
    rd(A_C0);
    check(rdv[15:0], 32'h16A5);
    wr(A_C1, 32'hA000);
    rd(A_C1);
    check(rdv[15:13], 32'h5);
  endtask

  task automatic bufferedReadout;
    startEvent(2, 15'h7FFE);
    check(busy, 1'b1);
    rd(A_ST);
    check(rdv[ST_BUSY], 1'b1);
    endEvent();
    check(busy, 1'b0);
    startEvent(0, 15'h0);
    endEvent();
    rd(A_ST);
    check(rdv[15:4], 32'h2);
    rd(A_DAT);
    check(rdv, hdr(3'd5, 3'b110));
    rd(A_DAT);
    check(rdv, {16'h0001, 16'h7FFE});
    rd(A_DAT);
    check(rdv, {16'h0001, 16'h7FFF});
    rd(A_DAT);
    check(rdv[DATA_Q], 1'b0);
    rd(A_DAT);
    check(rdv, hdr(3'd6, 3'b110));
    rd(A_DAT);
    check(rdv[DATA_Q], 1'b0);
    rd(A_DAT);
    check(rdv[DATA_Q], 1'b0);
  endtask

  task automatic suppressTest;
    wr(A_C0, 32'h36A5);
    startEvent(0, 15'h0);
    endEvent();
    rd(A_DAT);
    check(rdv[DATA_Q], 1'b0);
    rd(A_C1);
    check(rdv[15:13], 32'h0);
    startEvent(1, 15'h0C55);
    endEvent();
    rd(A_DAT);
    check(rdv, hdr(3'd0, 3'b110));
    rd(A_DAT);
    check(rdv, {16'h0001, 16'h0C55});
  endtask

  // Request delay of one step is 80 cycles at this clock
  task automatic unbufferedBusy;
    int n;
    rd(A_DAT);
    wr(A_C0, 32'h06A5);
    wr(A_C3, 32'h1);
    startEvent(0, 15'h0);
    repeat (78) @(posedge clk);
    check(busy, 1'b0);
    for (n = 0; n < 6 && busy !== 1'b1; n++) @(posedge clk);
    check(busy, 1'b1);
    endEvent();
    check(busy, 1'b1);
    rd(A_DAT);
    check(rdv, hdr(3'd1, 3'b110));
    rd(A_DAT);
    check(rdv[DATA_Q], 1'b0);
    repeat (3) @(posedge clk);
    check(busy, 1'b0);
  endtask

  task automatic eclPortTest;
    wr(A_C3, 32'h0);
    wr(A_C1, 32'h0);
    wr(A_C0, 32'h18A5);
    ackLag <= 2'd2;
    grant <= 1'b1;
    repeat (10) @(posedge clk);
    check(wordStrobe, 1'b0);
    startEvent(1, 15'h08AA);
    endEvent();
    waitPass(1'b1);
    grant <= 1'b0;
    check(partner.got.size(), 32'd2);
    check(partner.got[0], 32'h80A5);
    check(partner.got[1], 32'h08AA);
    startEvent(0, 15'h0);
    endEvent();
    waitPass(1'b0);
    repeat (20) @(posedge clk);
    check(partner.got.size(), 32'd2);
    ackLag <= 2'd0;
    grant <= 1'b1;
    waitPass(1'b1);
    grant <= 1'b0;
    check(partner.got.size(), 32'd3);
    check(partner.got[2], 32'h88A5);
    waitPass(1'b0);
  endtask

  // Fast port, single buffer; pause requested before the event
  task automatic fastPortTest;
    wr(A_C1, 32'h1000);
    wr(A_C0, 32'h08A5);
    fastAck <= 1'b1;
    pauseReq <= 1'b1;
    grant <= 1'b1;
    startEvent(2, 15'h1001);
    endEvent();
    repeat (20) @(posedge clk);
    check(partner.got.size(), 32'd4);
    check(partner.got[3], 32'h80A5);
    check(busy, 1'b1);
    pauseReq <= 1'b0;
    waitPass(1'b1);
    grant <= 1'b0;
    check(partner.got.size(), 32'd6);
    check(partner.got[4], 32'h1001);
    check(partner.got[5], 32'h1002);
    waitPass(1'b0);
    check(busy, 1'b0);
  endtask

  // Eight full events reach the half-full limit; a ninth is refused
  task automatic fillTest;
    wr(A_C0, 32'h18A5);
    repeat (8) begin
      startEvent(512, 15'h0);
      endEvent();
    end
    check(busy, 1'b1);
    rd(A_ST);
    check(rdv[28:4], {13'd4104, 12'd8});
    check(rdv[ST_BLOCK], 1'b1);
    startEvent(0, 15'h0);
    endEvent();
    rd(A_ST);
    check(rdv[15:4], 32'h8);
  endtask

  initial begin
    mismatches = 0;
    checked = 0;
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, acqEnd, hitValid, convDone, grant} = '0;
    {fastAck, pauseReq} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    ackLag = 2'd0;
    hitData = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    regTest();
    bufferedReadout();
    suppressTest();
    unbufferedBusy();
    eclPortTest();
    fastPortTest();
    fillTest();
    finish_test();
  end
endmodule // test_event_readout_port
